// File: src/hcp_dynpwr.sv
// watches the local supply and drops all links for a while on a change
// assumes the level is synchronous to clk
`timescale 1ns/100ps
`include "hcp_map.svh"
module hcp_dynpwr (
   input wire logic clk,
   input wire logic rst,
   hcp_if.dyn bus
);
   import hcp_pkg::*;
   localparam logic [9:0] DROP_LAST = 10'(`HCP_DROP_CYCLES - 1);
   typedef struct packed {
      logic armed;
      logic prev;
      logic cut;
      logic [9:0] cnt;
   } hcp_dyn_t;
   hcp_dyn_t s;
   hcp_dyn_t next_s;

   always_comb begin
      next_s = s;
      next_s.armed = bus.dynActive;
      next_s.prev = bus.localPowerDetect;
      if (s.cut) begin
         next_s.cnt = s.cnt + 10'h001;
         if (s.cnt == DROP_LAST) begin
            next_s.cut = 1'b0;
         end
      end
      // a change restarts the drop so the hub reattaches in the new mode
      if (bus.dynActive && s.armed && (bus.localPowerDetect != s.prev)) begin
         next_s.cut = 1'b1;
         next_s.cnt = 10'h000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.powerCut = s.cut;
   assign bus.upDisconnect = s.cut;

   a_change_cut: assert property (
      @(posedge clk) disable iff (rst)
      (bus.dynActive && s.armed && bus.localPowerDetect != s.prev) |=> bus.powerCut [*8])
      else $error("supply change did not drop the links");
endmodule

// File: src/hcp_if.sv
// signals between the configuration top and its two helpers
// one instance lives inside hcp_top
`timescale 1ns/100ps
interface hcp_if;
   logic localPowerDetect;
   logic dynActive;
   logic powerCut;
   logic upDisconnect;
   logic [1:0] ocRaw;
   logic [7:0] ocDelay;
   logic [1:0] ocReport;
   modport ctl(output localPowerDetect, dynActive, ocRaw, ocDelay, input powerCut, upDisconnect, ocReport);
   modport dyn(input localPowerDetect, dynActive, output powerCut, upDisconnect);
   modport oc(input ocRaw, ocDelay, output ocReport);
endinterface

// File: src/hcp_map.svh
// offsets, field positions, reset values and timing counts of the hub
// configuration block; included by every design file that needs them
`ifndef HCP_MAP_SVH
`define HCP_MAP_SVH
`define HCP_A_CTRL 8'h00
`define HCP_A_IDENT 8'h04
`define HCP_A_REL 8'h08
`define HCP_A_CFG 8'h0c
`define HCP_A_PORTS 8'h10
`define HCP_A_STAT 8'h14
`define HCP_C1_SELF 7
`define HCP_C1_HSDIS 5
`define HCP_C1_EOP 3
`define HCP_C1_GANG 1
`define HCP_C2_DYN 7
`define HCP_C2_COMP 3
`define HCP_SMB_ADDR 7'h2c
`define HCP_TT_PER_PORT 2'h1
`define HCP_TT_BUFS 3'h4
`define HCP_DEF_MAX_SELF 8'h01
`define HCP_DEF_OC_STEPS 8'h04
`define HCP_CLK_MHZ 100
`define HCP_OC_STEP_MS 2
`define HCP_OC_STEP_CYCLES (`HCP_OC_STEP_MS * 1000 * `HCP_CLK_MHZ)
`define HCP_DROP_US 10
`define HCP_DROP_CYCLES (`HCP_DROP_US * `HCP_CLK_MHZ)
`endif

// File: src/hcp_octimer.sv
// per-port over-current qualification in whole 2 ms steps
// assumes raw flags are synchronous to clk
`timescale 1ns/100ps
`include "hcp_map.svh"
module hcp_octimer #(
   parameter int STEP_CYCLES = `HCP_OC_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   hcp_if.oc bus
);
   import hcp_pkg::*;
   localparam logic [17:0] TICK_LAST = 18'(STEP_CYCLES - 1);
   typedef struct packed {
      logic [17:0] tick;
      logic [1:0][7:0] steps;
      logic [1:0] report;
   } hcp_oc_t;
   hcp_oc_t s;
   hcp_oc_t next_s;
   logic tickNow;
   logic [1:0][7:0] nextSteps;
   logic [1:0] nextRep;

   assign tickNow = (s.tick == TICK_LAST);
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         assign nextSteps[p] = !bus.ocRaw[p] ? 8'h00 :
            (tickNow && s.steps[p] != 8'hff) ? s.steps[p] + 8'h01 : s.steps[p];
         assign nextRep[p] = bus.ocRaw[p] && (s.steps[p] >= bus.ocDelay);
      end
   endgenerate

   always_comb begin
      next_s = s;
      next_s.tick = tickNow ? 18'h00000 : s.tick + 18'h00001;
      next_s.steps = nextSteps;
      next_s.report = nextRep;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.ocReport = s.report;

   a_oc_delay: assert property (
      @(posedge clk) disable iff (rst)
      bus.ocReport[0] |-> $past(bus.ocRaw[0]) && ($past(s.steps[0]) >= $past(bus.ocDelay)))
      else $error("over-current reported before its delay");
endmodule

// File: src/hcp_pkg.sv
// types of the hub configuration block
// assumes hcp_map.svh for the numeric constants
package hcp_pkg;
   typedef enum logic [2:0] {PH_STRAP = 3'b001, PH_LOAD = 3'b010, PH_RUN = 3'b100} hcp_phase_t;
   typedef enum logic [2:0] {SRC_SMBUS = 3'b001, SRC_DEFAULT = 3'b010, SRC_EEPROM = 3'b100} hcp_src_t;
   typedef struct packed {
      hcp_phase_t phase;
      hcp_src_t source;
      logic [1:0] nonRemStrap;
      logic loadDone;
      logic [15:0] dlVendor;
      logic [15:0] dlProduct;
      logic [15:0] dlRelease;
      logic [7:0] dlCfg1;
      logic [7:0] dlCfg2;
      logic [1:0] dlNonRem;
      logic [1:0] dlDisSelf;
      logic [1:0] dlDisBus;
      logic [7:0] dlMaxSelf;
      logic [7:0] dlOcDelay;
      logic [31:0] rdata;
      logic [15:0] vendor;
      logic [15:0] product;
      logic [15:0] release_;
      logic self;
      logic fsOnly;
      logic eop;
      logic gang;
      logic compound;
      logic [1:0] fixedPort;
      logic [1:0] portDis;
      logic [7:0] maxSelf;
      logic [7:0] ocDelay;
      logic attach;
   } hcp_top_t;
endpackage

// File: src/hcp_top.sv
// hub configuration source selection, option apply and power mode control
// assumes an APB master on clk, straps steady around reset release
//
// How it works
// - source chosen from straps after reset release
// - 01 SMBus slave, 10 defaults, 11 EEPROM
// - EEPROM data loaded before upstream attach
// - one TT per port, four buffers each
// - vendor code downloaded, else built-in
// - product code downloaded, else built-in
// - BCD release number downloaded, else built-in
// - power mode downloaded, else from detect pin
// - detect low bus power, high local supply
// - high-speed disable forces full-speed only
// - EOP at EOF1 option only in full speed
// - sensing ganged or none; defaults follow power
// - strapped fixed port implies compound device
// - fixed ports downloaded, else from straps
// - disable set of current mode kept off
// - dynamic mode: supply change drops and reattaches
// - dynamic mode: local supply means self-powered
// - over-current reported after configured 2 ms steps
// - self-powered max power in 2 mA units
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "hcp_map.svh"
module hcp_top #(
   parameter int OC_STEP_CYCLES = `HCP_OC_STEP_CYCLES,
   // built-in identity values, arbitrary
   parameter logic [15:0] DEF_VENDOR = 16'h0f0f,
   parameter logic [15:0] DEF_PRODUCT = 16'h0002,
   parameter logic [15:0] DEF_RELEASE = 16'h0100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic configSourceStrapHi,
   input wire logic configSourceStrapLo,
   input wire logic localPowerDetect,
   input wire logic [1:0] fixedDevicePortStraps,
   input wire logic linkHighSpeed,
   input wire logic [1:0] overCurrentRaw,
   output logic smbusSlaveEnable,
   output logic [6:0] smbusSlaveAddr,
   output logic eepromLoadEnable,
   output logic upstreamAttach,
   output logic downstreamPowerCut,
   output logic [15:0] vendorCode,
   output logic [15:0] productCode,
   output logic [15:0] releaseNumber,
   output logic selfPowered,
   output logic fullSpeedOnly,
   output logic sendEopAtEof1,
   output logic currentSenseGanged,
   output logic compoundDevice,
   output logic [1:0] fixedDevicePort,
   output logic [1:0] portDisabled,
   output logic [7:0] maxPowerSelf,
   output logic [8:0] maxPowerSelfMa,
   output logic [1:0] overCurrentReport,
   output logic [1:0] ttPerPort,
   output logic [2:0] ttBuffers
);
   import hcp_pkg::*;

   // ***************************************************************
   // state and helpers
   // ***************************************************************
   hcp_top_t s;
   hcp_top_t next_s;
   hcp_src_t strapSrc;
   logic isDef;
   logic dynOn;
   logic effSelf;
   logic effFsOnly;
   logic setup;
   logic wr;
   logic hit;
   logic [31:0] rd;
   hcp_if ifc();

   hcp_dynpwr u_dyn (
      .clk(clk),
      .rst(rst),
      .bus(ifc)
   );

   hcp_octimer #(
      .STEP_CYCLES(OC_STEP_CYCLES)
   ) u_oc (
      .clk(clk),
      .rst(rst),
      .bus(ifc)
   );

   // ***************************************************************
   // source decode and effective options
   // ***************************************************************
   always_comb begin
      case ({configSourceStrapHi, configSourceStrapLo})
         2'b01: strapSrc = SRC_SMBUS;
         2'b11: strapSrc = SRC_EEPROM;
         default: strapSrc = SRC_DEFAULT;
      endcase
   end

   assign isDef = (s.source == SRC_DEFAULT);
   assign dynOn = !isDef && s.dlCfg2[`HCP_C2_DYN];
   // under dynamic power the pin rules, local supply always wins
   assign effSelf = (isDef || dynOn) ? localPowerDetect : s.dlCfg1[`HCP_C1_SELF];
   assign effFsOnly = !isDef && s.dlCfg1[`HCP_C1_HSDIS];

   assign ifc.localPowerDetect = localPowerDetect;
   assign ifc.dynActive = dynOn && (s.phase == PH_RUN);
   assign ifc.ocRaw = overCurrentRaw;
   assign ifc.ocDelay = s.ocDelay;

   // ***************************************************************
   // register read decode
   // ***************************************************************
   always_comb begin
      rd = 32'h00000000;
      hit = 1'b1;
      case (paddr)
         `HCP_A_CTRL: rd = {31'h00000000, s.loadDone};
         `HCP_A_IDENT: rd = {s.dlProduct, s.dlVendor};
         `HCP_A_REL: rd = {16'h0000, s.dlRelease};
         `HCP_A_CFG: rd = {14'h0000, s.dlNonRem, s.dlCfg2, s.dlCfg1};
         `HCP_A_PORTS: rd = {s.dlOcDelay, s.dlMaxSelf, 6'h00, s.dlDisBus, 6'h00, s.dlDisSelf};
         `HCP_A_STAT: rd = {19'h00000, s.compound, s.portDis, ifc.ocReport, 1'b0,
            ifc.powerCut, s.self, s.attach, 1'b0, s.source};
         default: hit = 1'b0;
      endcase
   end

   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_s = s;
      case (s.phase)
         PH_STRAP: begin
            // straps are read once, right after reset release
            next_s.source = strapSrc;
            next_s.nonRemStrap = fixedDevicePortStraps;
            next_s.phase = PH_LOAD;
         end
         PH_LOAD: begin
            if (isDef || s.loadDone) begin
               next_s.phase = PH_RUN;
            end
         end
         PH_RUN: begin
            next_s.phase = PH_RUN;
         end
         default: begin
            next_s.phase = PH_STRAP;
         end
      endcase

      if (setup) begin
         next_s.rdata = rd;
      end
      if (wr) begin
         case (paddr)
            `HCP_A_CTRL: begin
               if (pwdata[0]) begin
                  next_s.loadDone = 1'b1;
               end
            end
            `HCP_A_IDENT: begin
               next_s.dlVendor = pwdata[15:0];
               next_s.dlProduct = pwdata[31:16];
            end
            `HCP_A_REL: begin
               next_s.dlRelease = pwdata[15:0];
            end
            `HCP_A_CFG: begin
               next_s.dlCfg1 = pwdata[7:0];
               next_s.dlCfg2 = pwdata[15:8];
               next_s.dlNonRem = pwdata[17:16];
            end
            `HCP_A_PORTS: begin
               next_s.dlDisSelf = pwdata[1:0];
               next_s.dlDisBus = pwdata[9:8];
               next_s.dlMaxSelf = pwdata[23:16];
               next_s.dlOcDelay = pwdata[31:24];
            end
            default: begin
               next_s.loadDone = s.loadDone;
            end
         endcase
      end

      next_s.vendor = isDef ? DEF_VENDOR : s.dlVendor;
      next_s.product = isDef ? DEF_PRODUCT : s.dlProduct;
      next_s.release_ = isDef ? DEF_RELEASE : s.dlRelease;
      next_s.self = effSelf;
      next_s.fsOnly = effFsOnly;
      next_s.eop = !isDef && s.dlCfg1[`HCP_C1_EOP] && (effFsOnly || !linkHighSpeed);
      next_s.gang = isDef ? effSelf : s.dlCfg1[`HCP_C1_GANG];
      next_s.compound = isDef ? |s.nonRemStrap : s.dlCfg2[`HCP_C2_COMP];
      next_s.fixedPort = isDef ? s.nonRemStrap : s.dlNonRem;
      next_s.portDis = isDef ? 2'b00 : (effSelf ? s.dlDisSelf : s.dlDisBus);
      next_s.maxSelf = isDef ? `HCP_DEF_MAX_SELF : s.dlMaxSelf;
      next_s.ocDelay = isDef ? `HCP_DEF_OC_STEPS : s.dlOcDelay;
      next_s.attach = (s.phase == PH_RUN) && !ifc.upDisconnect;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{phase: PH_STRAP, source: SRC_DEFAULT, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign smbusSlaveEnable = (s.source == SRC_SMBUS) && (s.phase != PH_STRAP);
   assign smbusSlaveAddr = `HCP_SMB_ADDR;
   assign eepromLoadEnable = (s.source == SRC_EEPROM) && (s.phase == PH_LOAD);
   assign upstreamAttach = s.attach;
   assign downstreamPowerCut = ifc.powerCut;
   assign vendorCode = s.vendor;
   assign productCode = s.product;
   assign releaseNumber = s.release_;
   assign selfPowered = s.self;
   assign fullSpeedOnly = s.fsOnly;
   assign sendEopAtEof1 = s.eop;
   assign currentSenseGanged = s.gang;
   assign compoundDevice = s.compound;
   assign fixedDevicePort = s.fixedPort;
   assign portDisabled = s.portDis;
   assign maxPowerSelf = s.maxSelf;
   assign maxPowerSelfMa = {s.maxSelf, 1'b0};
   assign overCurrentReport = ifc.ocReport;
   assign ttPerPort = `HCP_TT_PER_PORT;
   assign ttBuffers = `HCP_TT_BUFS;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_strap_sample: assert property (
      (s.phase == PH_STRAP) |=> (s.source == $past(strapSrc)) && (s.phase == PH_LOAD))
      else $error("straps not latched at release");

   a_source_held: assert property (
      (s.phase != PH_STRAP) |=> $stable(s.source))
      else $error("source changed after latch");

   a_smbus_mode: assert property (
      (s.source == SRC_SMBUS && s.phase != PH_STRAP) |-> smbusSlaveEnable && !eepromLoadEnable)
      else $error("smbus mode not enabled");

   a_attach_wait: assert property (
      (s.source == SRC_EEPROM && !s.loadDone) |-> !upstreamAttach && !$past(upstreamAttach))
      else $error("attached before eeprom load");

   a_vendor_src: assert property (
      (isDef && s.phase == PH_RUN) |=> vendorCode == DEF_VENDOR)
      else $error("built-in vendor code missing");

   a_product_src: assert property (
      (!isDef && s.phase == PH_RUN) |=> productCode == $past(s.dlProduct))
      else $error("downloaded product code not used");

   a_power_pin: assert property (
      (isDef || dynOn) |=> selfPowered == $past(localPowerDetect))
      else $error("power mode does not follow detect pin");

   a_hs_off: assert property (
      (!isDef && s.dlCfg1[`HCP_C1_HSDIS]) |=> fullSpeedOnly)
      else $error("high speed still offered");

   a_eop_fs: assert property (
      sendEopAtEof1 |-> $past(effFsOnly || !linkHighSpeed))
      else $error("eop option active in high speed");

   a_sense_def: assert property (
      isDef |=> currentSenseGanged == $past(effSelf))
      else $error("default sensing does not follow power mode");

   a_compound_strap: assert property (
      (isDef && |s.nonRemStrap) |=> compoundDevice)
      else $error("fixed port strap without compound");

   a_port_off: assert property (
      (!isDef && effSelf) |=> portDisabled == $past(s.dlDisSelf))
      else $error("self-powered disable set not applied");

   a_power_units: assert property (
      !isDef |=> maxPowerSelfMa == 9'($past(s.dlMaxSelf)) * 9'h002)
      else $error("max power not in 2 mA units");

   a_release_src: assert property (
      (!isDef && s.phase == PH_RUN) |=> releaseNumber == $past(s.dlRelease))
      else $error("downloaded release number not used");

   a_self_dl: assert property (
      (!isDef && !dynOn) |=> selfPowered == $past(s.dlCfg1[`HCP_C1_SELF]))
      else $error("downloaded power mode not used");

   a_sense_dl: assert property (
      !isDef |=> currentSenseGanged == $past(s.dlCfg1[`HCP_C1_GANG]))
      else $error("downloaded sensing mode not used");

   a_fixed_strap: assert property (
      isDef |=> fixedDevicePort == $past(s.nonRemStrap))
      else $error("fixed ports do not follow straps");

   a_bus_off: assert property (
      (!isDef && !effSelf) |=> portDisabled == $past(s.dlDisBus))
      else $error("bus-powered disable set not applied");

   a_dyn_self: assert property (
      (dynOn && localPowerDetect) |=> selfPowered)
      else $error("local supply without self-powered mode");

   a_eeprom_wait: assert property (
      (s.source == SRC_EEPROM && s.phase == PH_LOAD) |-> eepromLoadEnable && !upstreamAttach)
      else $error("eeprom load not pending before attach");
endmodule

// File: verif/hcp_host_model.sv
// upstream host controller model: grants high speed only when offered
// assumes attach and full-speed-only levels are registered on clk
`timescale 1ns/100ps
module hcp_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic upstreamAttach,
   input wire logic fullSpeedOnly,
   output logic linkHighSpeed
);
   // ****************************************
   // link training
   // ****************************************
   // the link drops to full speed on the clock after the hub detaches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         linkHighSpeed <= 1'b0;
      end else begin
         linkHighSpeed <= upstreamAttach && !fullSpeedOnly;
      end
   end
endmodule

// File: verif/hcp_top_tb_top.sv
// self-checking bench of the hub configuration block
// assumes hcp_top with a short over-current step and the host model
`timescale 1ns/100ps
`include "hcp_map.svh"
module hcp_top_tb_top;
   localparam int STEP = 20;
   // built-in identity values, arbitrary
   localparam logic [15:0] VEN = 16'h1a2b;
   localparam logic [15:0] PRO = 16'h0033;
   localparam logic [15:0] REL = 16'h0210;
   typedef struct {string nm; int sel; logic [31:0] e;} hcp_note_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, linkHighSpeed, lastErr;
   logic configSourceStrapHi, configSourceStrapLo, localPowerDetect;
   logic smbusSlaveEnable, eepromLoadEnable, upstreamAttach, downstreamPowerCut, selfPowered;
   logic fullSpeedOnly, sendEopAtEof1, currentSenseGanged, compoundDevice;
   logic [1:0] fixedDevicePortStraps, overCurrentRaw, fixedDevicePort, portDisabled;
   logic [1:0] overCurrentReport, ttPerPort;
   logic [7:0] paddr, maxPowerSelf;
   logic [31:0] pwdata, prdata;
   logic [6:0] smbusSlaveAddr;
   logic [15:0] vendorCode, productCode, releaseNumber;
   logic [8:0] maxPowerSelfMa;
   logic [2:0] ttBuffers;
   hcp_note_t notes[$];
   int badCount, checked, cyc;
   event obsEv;

   hcp_top #(.OC_STEP_CYCLES(STEP), .DEF_VENDOR(VEN), .DEF_PRODUCT(PRO), .DEF_RELEASE(REL)) dut (
      .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .configSourceStrapHi, .configSourceStrapLo, .localPowerDetect, .fixedDevicePortStraps,
      .linkHighSpeed, .overCurrentRaw, .smbusSlaveEnable, .smbusSlaveAddr, .eepromLoadEnable,
      .upstreamAttach, .downstreamPowerCut, .vendorCode, .productCode, .releaseNumber,
      .selfPowered, .fullSpeedOnly, .sendEopAtEof1, .currentSenseGanged, .compoundDevice,
      .fixedDevicePort, .portDisabled, .maxPowerSelf, .maxPowerSelfMa, .overCurrentReport,
      .ttPerPort, .ttBuffers
   );
   hcp_host_model host (.clk, .rst, .upstreamAttach, .fullSpeedOnly, .linkHighSpeed);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // scoreboard
   // ****************************************
   function automatic logic [31:0] pick(input int s);
      case (s)
         1: return 32'(vendorCode);
         2: return 32'(productCode);
         3: return 32'(releaseNumber);
         4: return 32'(selfPowered);
         5: return 32'(fullSpeedOnly);
         6: return 32'(sendEopAtEof1);
         7: return 32'(currentSenseGanged);
         8: return 32'(compoundDevice);
         9: return 32'(fixedDevicePort);
         10: return 32'(portDisabled);
         11: return 32'(maxPowerSelf);
         12: return 32'(maxPowerSelfMa);
         13: return 32'(overCurrentReport);
         14: return 32'({ttPerPort, 1'b0, ttBuffers});
         15: return 32'(smbusSlaveEnable);
         16: return 32'(smbusSlaveAddr);
         17: return 32'(eepromLoadEnable);
         18: return 32'(upstreamAttach);
         19: return 32'(downstreamPowerCut);
         default: return 32'(lastErr);
      endcase
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      checked++;
      if (seen !== e) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", nm, e, seen);
      end
   endtask

   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && notes.size() > 0) begin
         check(notes[0].nm, prdata, notes[0].e);
         void'(notes.pop_front());
      end
   end

   always @(obsEv) begin
      while (notes.size() > 0 && notes[0].sel > 0) begin
         check(notes[0].nm, pick(notes[0].sel), notes[0].e);
         void'(notes.pop_front());
      end
   end

   task automatic printVerdict();
      $display("counts: %0d checked, %0d mismatched", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         badCount++;
         printVerdict();
      end
   end

   // ****************************************
   // drivers
   // ****************************************
   task automatic look(input string nm, input int sel, input logic [31:0] e);
      notes.push_back('{nm, sel, e});
      ->obsEv;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      notes.push_back('{nm, 0, e});
      apb(1'b0, a, 32'h0);
      // let the read watcher take its note before any later look
      #1;
   endtask

   task automatic boot(input logic [1:0] code, input logic lp, input logic [1:0] fx);
      @(posedge clk);
      rst <= 1'b1;
      {configSourceStrapHi, configSourceStrapLo} <= code;
      localPowerDetect <= lp;
      fixedDevicePortStraps <= fx;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      // straps move once they have been taken
      {configSourceStrapHi, configSourceStrapLo} <= ~code;
      fixedDevicePortStraps <= ~fx;
      tick(4);
   endtask

   task automatic ocTest(input int d, input logic [1:0] p);
      int n;
      @(posedge clk);
      overCurrentRaw <= p;
      tick((d > 0) ? (d - 1) * STEP : 0);
      look("ocEarly", 13, 0);
      n = 0;
      while (overCurrentReport !== p && n < 2 * STEP + 4) begin
         tick(1);
         n++;
      end
      look("ocReport", 13, 32'(p));
      @(posedge clk);
      overCurrentRaw <= 2'b00;
      tick(2);
      look("ocClear", 13, 0);
   endtask

   task automatic dynFlip(input logic lp);
      int n;
      @(posedge clk);
      localPowerDetect <= lp;
      tick(3);
      look("powerCut", 19, 1);
      look("attach", 18, 0);
      tick(985);
      look("cutHeld", 19, 1);
      n = 0;
      while (upstreamAttach !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      look("reattach", 18, 1);
      look("powerCut", 19, 0);
      look("selfPowered", 4, 32'(lp));
      look("portDisabled", 10, lp ? 32'h2 : 32'h3);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      logic [1:0] code;
      logic [31:0] ven, rel, mp, ports;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      configSourceStrapHi = 1'b1;
      configSourceStrapLo = 1'b0;
      localPowerDetect = 1'b0;
      fixedDevicePortStraps = 2'b00;
      overCurrentRaw = 2'b00;
      lastErr = 1'b0;
      void'($urandom(43596));
      for (int c = 0; c < 4; c++) begin
         code = 2'(c);
         boot(code, 1'b0, 2'b00);
         look("smbusEnable", 15, 32'(code == 2'b01));
         look("smbusAddr", 16, 32'h2c);
         look("eepromLoad", 17, 32'(code == 2'b11));
         rd("status", 8'h14, code == 2'b01 ? 32'h1 : code == 2'b11 ? 32'h4 : 32'h12);
      end
      $display("source selection test done");
      boot(2'b10, 1'b1, 2'b01);
      look("vendor", 1, 32'(VEN));
      look("product", 2, 32'(PRO));
      look("release", 3, 32'(REL));
      look("selfPowered", 4, 1);
      look("ganged", 7, 1);
      look("compound", 8, 1);
      look("fixedPort", 9, 1);
      look("maxPowerMa", 12, 32'(`HCP_DEF_MAX_SELF) * 2);
      look("translators", 14, 32'({`HCP_TT_PER_PORT, 1'b0, `HCP_TT_BUFS}));
      $display("internal defaults test done");
      boot(2'b11, 1'b1, 2'b00);
      ven = $urandom();
      rel = $urandom();
      mp = $urandom();
      // disables run down from port 2; compound marks port 2 fixed
      ports = {8'h03, mp[7:0], 8'h03, 8'h02};
      apb(1'b1, 8'h04, ven);
      apb(1'b1, 8'h08, rel);
      apb(1'b1, 8'h0c, {14'h0, 2'b10, 8'h08, 6'h2a, mp[8], 1'b0});
      apb(1'b1, 8'h10, ports);
      tick(3);
      look("attachEarly", 18, 0);
      apb(1'b1, 8'h00, 32'h1);
      tick(4);
      look("eepromLoad", 17, 0);
      look("attach", 18, 1);
      look("vendor", 1, 32'(ven[15:0]));
      look("product", 2, 32'(ven[31:16]));
      look("release", 3, 32'(rel[15:0]));
      look("selfPowered", 4, 1);
      look("fullSpeedOnly", 5, 1);
      look("eop", 6, 1);
      look("ganged", 7, 32'(mp[8]));
      look("compound", 8, 1);
      look("fixedPort", 9, 2);
      look("portDisabled", 10, 2);
      look("maxPower", 11, 32'(mp[7:0]));
      look("maxPowerMa", 12, {23'h0, mp[7:0], 1'b0});
      rd("unmapped", 8'h18, 32'h0);
      look("slverr", 20, 1);
      apb(1'b1, 8'h14, 32'hffffffff);
      rd("status", 8'h14, 32'h1834);
      ocTest(3, 2'b01);
      apb(1'b1, 8'h10, {8'h00, ports[23:0]});
      ocTest(0, 2'b10);
      apb(1'b1, 8'h0c, {14'h0, 2'b10, 8'h08, 8'h08});
      tick(6);
      look("selfPowered", 4, 0);
      look("portDisabled", 10, 3);
      look("fullSpeedOnly", 5, 0);
      look("eopInHs", 6, 0);
      $display("eeprom load test done");
      apb(1'b1, 8'h0c, {14'h0, 2'b10, 8'h88, 8'h08});
      tick(3);
      dynFlip(1'b0);
      dynFlip(1'b1);
      tick(1);
      $display("dynamic power test done");
      printVerdict();
   end
endmodule
